// File: hw/dod_pkg.sv
package dod_pkg;
  // ----------------------------------------------------------------
  // operation selects
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    DOD_OP_NONE         = 5'h00,
    DOD_OP_POP_ACC      = 5'h01,
    DOD_OP_POP_MEM      = 5'h02,
    DOD_OP_PUSH_MEM     = 5'h03,
    DOD_OP_PUSH_ACC     = 5'h04,
    DOD_OP_COND_RET     = 5'h05,
    DOD_OP_REPEAT_IMM   = 5'h06,
    DOD_OP_REPEAT_MEM   = 5'h07,
    DOD_OP_STORE_HIGH   = 5'h08,
    DOD_OP_STORE_LOW    = 5'h09,
    DOD_OP_AUX_SUB_IMM  = 5'h0a,
    DOD_OP_SET_CTRL     = 5'h0b,
    DOD_OP_STORE_STATUS_ZERO = 5'h0c,
    DOD_OP_STORE_STATUS_ONE = 5'h0d,
    DOD_OP_STORE_LONG   = 5'h0e,
    DOD_OP_SUB_LONG     = 5'h0f,
    DOD_OP_SUB_SHORT    = 5'h10,
    DOD_OP_SUB_BORROW   = 5'h11,
    DOD_OP_SUB_NO_SEXT  = 5'h12,
    DOD_OP_SUB_BY_TEMP  = 5'h13,
    DOD_OP_XOR_LONG16   = 5'h14,
    DOD_OP_ZERO_LD_RND  = 5'h15,
    DOD_OP_SQUARE_SUB   = 5'h16,
    DOD_OP_SUB_PRODUCT  = 5'h17,
    DOD_OP_UNDEFINED    = 5'h1f
  } dod_op_t;

  // control bit selects for set_control_bit
  typedef enum logic [2:0] {
    DOD_CB_NONE  = 3'h0,
    DOD_CB_CARRY = 3'h1,
    DOD_CB_PROG  = 3'h2,
    DOD_CB_INTM  = 3'h3,
    DOD_CB_OVM   = 3'h4,
    DOD_CB_TC    = 3'h5,
    DOD_CB_EXT_FLAG = 3'h6,
    DOD_CB_SXM   = 3'h7
  } dod_cbit_t;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] DOD_W_POP_ACC = 16'hbe32;
  localparam logic [15:0] DOD_W_PUSH_ACC = 16'hbe3c;
  localparam logic [15:0] DOD_W_XOR_LONG16 = 16'hbe83;
  localparam logic [15:0] DOD_W_SUB_PRODUCT = 16'hbe05;
  localparam logic [7:0] DOD_B_POP_MEM = 8'h8a;
  localparam logic [7:0] DOD_B_PUSH_MEM = 8'h76;
  localparam logic [7:0] DOD_B_REPEAT_IMM = 8'hbb;
  localparam logic [7:0] DOD_B_REPEAT_MEM = 8'h0b;
  localparam logic [7:0] DOD_B_AUX_SUB = 8'h7c;
  localparam logic [7:0] DOD_B_STATUS_ZERO = 8'h8e;
  localparam logic [7:0] DOD_B_STATUS_ONE = 8'h8f;
  localparam logic [7:0] DOD_B_STORE_LONG = 8'hae;
  localparam logic [7:0] DOD_B_SUB_SHORT = 8'hba;
  localparam logic [7:0] DOD_B_SUB_BORROW = 8'h64;
  localparam logic [7:0] DOD_B_SUB_NO_SEXT = 8'h66;
  localparam logic [7:0] DOD_B_SUB_BY_TEMP = 8'h67;
  localparam logic [7:0] DOD_B_ZERO_LD_RND = 8'h68;
  localparam logic [7:0] DOD_B_SQUARE_SUB = 8'h53;
  localparam logic [5:0] DOD_P_COND_RET = 6'h3b;
  localparam logic [3:0] DOD_N_STORE_ACC = 4'h9;
  localparam logic [11:0] DOD_P_SUB_LONG = 12'hbfa;
  localparam logic [11:0] DOD_P_SET_CTRL = 12'hbe4;
  localparam logic [3:0] DOD_C_CARRY = 4'hf;
  localparam logic [3:0] DOD_C_PROG = 4'h5;
  localparam logic [3:0] DOD_C_INTM = 4'h1;
  localparam logic [3:0] DOD_C_OVM = 4'h3;
  localparam logic [3:0] DOD_C_TC = 4'hb;
  localparam logic [3:0] DOD_C_EXT_FLAG = 4'hd;
  localparam logic [3:0] DOD_C_SXM = 4'h7;

  // field positions
  localparam int DOD_HIGH_SEL_BIT = 11;
  localparam int DOD_SHIFT3_MSB = 10;
  localparam int DOD_SHIFT3_LSB = 8;
  localparam int DOD_OPC_MSB = 15;
  localparam int DOD_PFX12_LSB = 4;
  localparam int DOD_PFX6_LSB = 10;
  localparam int DOD_TOP_NIB_LSB = 12;
  localparam int DOD_TOP_BYTE_LSB = 8;
  localparam int DOD_LOW_BYTE_MSB = 7;
  localparam int DOD_LOW_BYTE_LSB = 0;
  localparam int DOD_LOW_NIB_MSB = 3;
  localparam int DOD_LOW_NIB_LSB = 0;
  localparam int DOD_TP_MSB = 9;
  localparam int DOD_TP_LSB = 8;
  localparam int DOD_COND_MASK_MSB = 7;
  localparam int DOD_COND_MASK_LSB = 4;
  // low pad of the packed condition bits
  localparam logic [1:0] DOD_COND_PAD = 2'h0;

  // words and cycles
  localparam logic [1:0] DOD_ONE = 2'h1;
  localparam logic [1:0] DOD_TWO = 2'h2;
  localparam logic [2:0] DOD_CYC_ONE = 3'h1;
  localparam logic [2:0] DOD_CYC_TWO = 3'h2;
  localparam logic [2:0] DOD_CYC_RET_TAKEN = 3'h4;
  localparam logic [2:0] DOD_CYC_RET_NOT = 3'h2;
endpackage

// File: hw/dod_ctrl_sel.sv
`timescale 1ns/1ps
`default_nettype none
module dod_ctrl_sel (
  input wire logic [3:0] code,
  output dod_pkg::dod_cbit_t sel
);
  import dod_pkg::*;
  // low nibble to control bit select
  always_comb begin
    case (code)
      DOD_C_CARRY: sel = DOD_CB_CARRY;
      DOD_C_PROG: sel = DOD_CB_PROG;
      DOD_C_INTM: sel = DOD_CB_INTM;
      DOD_C_OVM: sel = DOD_CB_OVM;
      DOD_C_TC: sel = DOD_CB_TC;
      DOD_C_EXT_FLAG: sel = DOD_CB_EXT_FLAG;
      DOD_C_SXM: sel = DOD_CB_SXM;
      default: sel = DOD_CB_NONE;
    endcase
  end
endmodule // dod_ctrl_sel
`default_nettype wire

// File: hw/dod_word_cnt.sv
`timescale 1ns/1ps
`default_nettype none
module dod_word_cnt (
  input wire dod_pkg::dod_op_t op,
  output logic [1:0] words,
  output logic [2:0] cyc_taken,
  output logic [2:0] cyc_not
);
  import dod_pkg::*;
  // word and cycle counts per operation
  always_comb begin
    words = DOD_ONE;
    cyc_taken = DOD_CYC_ONE;
    cyc_not = DOD_CYC_ONE;
    case (op)
      DOD_OP_STORE_LONG, DOD_OP_SUB_LONG, DOD_OP_XOR_LONG16: begin
        words = DOD_TWO;
        cyc_taken = DOD_CYC_TWO;
        cyc_not = DOD_CYC_TWO;
      end
      DOD_OP_COND_RET: begin
        cyc_taken = DOD_CYC_RET_TAKEN;
        cyc_not = DOD_CYC_RET_NOT;
      end
      default: begin
        words = DOD_ONE;
      end
    endcase
  end
endmodule // dod_word_cnt
`default_nettype wire

// File: hw/dod_decoder.sv
// Summary of operation
// - word be32 pops stack top into low accumulator, one word one cycle
// - upper byte 8a pops stack top into addressed data memory
// - upper byte 76 pushes addressed data memory onto stack
// - word be3c pushes low accumulator onto stack
// - upper bits 111011 are conditional return, four cycles taken, two not
// - upper byte bb loads repeat count from low immediate byte
// - upper byte 0b loads repeat count from addressed data memory
// - upper nibble 9 stores accumulator; bit 11 picks high or low half
// - upper byte 7c subtracts immediate byte from current auxiliary register
// - words be4x set a control bit chosen by low nibble f, 5, 1, 3, b, d or 7; other be4x words are undefined
// - upper bytes 8e and 8f store status register zero or one
// - upper byte ae stores following constant word to memory, two words
// - bfa plus shift nibble subtracts shifted following constant, two words
// - upper byte ba subtracts unsigned immediate byte from accumulator
// - upper bytes 64 and 66 are borrow subtract and unextended low subtract
// - upper byte 67 subtracts operand shifted by temp multiplier register
// - word be83 xors accumulator with following constant shifted by 16
// - upper byte 68 zeroes low half, loads high half rounded
// - upper byte 53 squares operand and subtracts previous product
// - word be05 subtracts product register from accumulator
`timescale 1ns/1ps
`default_nettype none
module dod_decoder (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic word_valid,
  input wire logic [15:0] word_in,
  output logic dec_valid,
  output dod_pkg::dod_op_t dec_op,
  output logic [7:0] dec_addr_field,
  output logic [7:0] dec_imm8,
  output logic [3:0] dec_shift,
  output logic [15:0] dec_const,
  output dod_pkg::dod_cbit_t dec_cbit,
  output logic [7:0] dec_cond_bits,
  output logic [1:0] dec_words,
  output logic [2:0] dec_cyc_taken,
  output logic [2:0] dec_cyc_not,
  output logic dec_undefined,
  output logic want_const
);
  import dod_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    DOD_ST_FIRST = 1'b0,
    DOD_ST_CONST = 1'b1
  } dod_state_t;

  dod_state_t state_r;
  dod_state_t state_nxt;
  logic [15:0] held_r;
  dod_op_t held_op_r;
  dod_op_t op_nxt;
  dod_cbit_t cbit_code;
  logic [1:0] w_cnt;
  logic [2:0] c_taken;
  logic [2:0] c_not;
  logic [15:0] cur_word;
  logic [11:0] in_pfx12;
  logic [5:0] in_pfx6;
  logic [3:0] in_top_nib;
  logic [7:0] in_top_byte;
  logic [3:0] in_low_nib;
  logic take_result;
  logic [7:0] cur_low_byte;
  logic [3:0] cur_low_nib;
  logic [3:0] cur_top_nib;
  logic [2:0] cur_shift3;
  logic [1:0] cur_tp;
  logic [3:0] cur_cond_mask;

  // function: is this opcode a two-word form
  function automatic logic is_two_word(input dod_op_t op);
    is_two_word = (op == DOD_OP_STORE_LONG) || (op == DOD_OP_SUB_LONG) ||
                  (op == DOD_OP_XOR_LONG16);
  endfunction

  // ----------------------------------------------------------------
  // field slices
  // ----------------------------------------------------------------
  // slices of the word on the fetch bus, read by the opcode match; the low nibble also feeds dec_cbit
  assign in_pfx12 = word_in[DOD_OPC_MSB:DOD_PFX12_LSB];
  assign in_pfx6 = word_in[DOD_OPC_MSB:DOD_PFX6_LSB];
  assign in_top_nib = word_in[DOD_OPC_MSB:DOD_TOP_NIB_LSB];
  assign in_top_byte = word_in[DOD_OPC_MSB:DOD_TOP_BYTE_LSB];
  assign in_low_nib = word_in[DOD_LOW_NIB_MSB:DOD_LOW_NIB_LSB];

  // a result loads on a one-word op, or on the constant of a long op
  assign take_result = word_valid && (state_r == DOD_ST_CONST || !is_two_word(op_nxt));

  // ----------------------------------------------------------------
  // opcode match
  // ----------------------------------------------------------------
  // full-word matches checked first, since they overlap prefix ranges
  always_comb begin
    op_nxt = DOD_OP_UNDEFINED;
    if (word_in == DOD_W_POP_ACC) begin
      op_nxt = DOD_OP_POP_ACC;
    end else if (word_in == DOD_W_PUSH_ACC) begin
      op_nxt = DOD_OP_PUSH_ACC;
    end else if (word_in == DOD_W_XOR_LONG16) begin
      op_nxt = DOD_OP_XOR_LONG16;
    end else if (word_in == DOD_W_SUB_PRODUCT) begin
      op_nxt = DOD_OP_SUB_PRODUCT;
    end else if (in_pfx12 == DOD_P_SET_CTRL && cbit_code != DOD_CB_NONE) begin
      op_nxt = DOD_OP_SET_CTRL;
    end else if (in_pfx12 == DOD_P_SUB_LONG) begin
      op_nxt = DOD_OP_SUB_LONG;
    end else if (in_pfx6 == DOD_P_COND_RET) begin
      op_nxt = DOD_OP_COND_RET;
    end else if (in_top_nib == DOD_N_STORE_ACC) begin
      op_nxt = word_in[DOD_HIGH_SEL_BIT] ? DOD_OP_STORE_HIGH : DOD_OP_STORE_LOW;
    end else begin
      case (in_top_byte)
        DOD_B_POP_MEM: op_nxt = DOD_OP_POP_MEM;
        DOD_B_PUSH_MEM: op_nxt = DOD_OP_PUSH_MEM;
        DOD_B_REPEAT_IMM: op_nxt = DOD_OP_REPEAT_IMM;
        DOD_B_REPEAT_MEM: op_nxt = DOD_OP_REPEAT_MEM;
        DOD_B_AUX_SUB: op_nxt = DOD_OP_AUX_SUB_IMM;
        DOD_B_STATUS_ZERO: op_nxt = DOD_OP_STORE_STATUS_ZERO;
        DOD_B_STATUS_ONE: op_nxt = DOD_OP_STORE_STATUS_ONE;
        DOD_B_STORE_LONG: op_nxt = DOD_OP_STORE_LONG;
        DOD_B_SUB_SHORT: op_nxt = DOD_OP_SUB_SHORT;
        DOD_B_SUB_BORROW: op_nxt = DOD_OP_SUB_BORROW;
        DOD_B_SUB_NO_SEXT: op_nxt = DOD_OP_SUB_NO_SEXT;
        DOD_B_SUB_BY_TEMP: op_nxt = DOD_OP_SUB_BY_TEMP;
        DOD_B_ZERO_LD_RND: op_nxt = DOD_OP_ZERO_LD_RND;
        DOD_B_SQUARE_SUB: op_nxt = DOD_OP_SQUARE_SUB;
        default: op_nxt = DOD_OP_UNDEFINED;
      endcase
    end
  end

  dod_ctrl_sel u_ctrl_sel (
    .code(in_low_nib),
    .sel(cbit_code)
  );

  // counts follow the op being emitted next
  dod_word_cnt u_word_cnt (
    .op(state_r == DOD_ST_CONST ? held_op_r : op_nxt),
    .words(w_cnt),
    .cyc_taken(c_taken),
    .cyc_not(c_not)
  );

  // ----------------------------------------------------------------
  // two-word sequencing
  // ----------------------------------------------------------------
  // wait for constant word
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DOD_ST_FIRST: begin
        if (word_valid && is_two_word(op_nxt)) begin
          state_nxt = DOD_ST_CONST;
        end
      end
      DOD_ST_CONST: begin
        if (word_valid) begin
          state_nxt = DOD_ST_FIRST;
        end
      end
      default: state_nxt = DOD_ST_FIRST;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= DOD_ST_FIRST;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      held_r <= 16'h0000;
      held_op_r <= DOD_OP_NONE;
    end else if (state_r == DOD_ST_FIRST && word_valid && is_two_word(op_nxt)) begin
      held_r <= word_in;
      held_op_r <= op_nxt;
    end
  end

  // first word of the current result
  assign cur_word = (state_r == DOD_ST_CONST) ? held_r : word_in;

  // slices of the first word; a long op takes them from the held copy
  assign cur_low_byte = cur_word[DOD_LOW_BYTE_MSB:DOD_LOW_BYTE_LSB];
  assign cur_low_nib = cur_word[DOD_LOW_NIB_MSB:DOD_LOW_NIB_LSB];
  assign cur_top_nib = cur_word[DOD_OPC_MSB:DOD_TOP_NIB_LSB];
  assign cur_shift3 = cur_word[DOD_SHIFT3_MSB:DOD_SHIFT3_LSB];
  assign cur_tp = cur_word[DOD_TP_MSB:DOD_TP_LSB];
  assign cur_cond_mask = cur_word[DOD_COND_MASK_MSB:DOD_COND_MASK_LSB];

  // want_const tells fetch the next word is data, not an opcode
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      want_const <= 1'b0;
    end else begin
      want_const <= (state_nxt == DOD_ST_CONST);
    end
  end

  // ----------------------------------------------------------------
  // result outputs
  // ----------------------------------------------------------------
  // result strobe, one cycle per completed op
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= take_result;
    end
  end

  // operation and undefined flag; a constant word is never decoded as an op
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_op <= DOD_OP_NONE;
      dec_undefined <= 1'b0;
    end else if (word_valid && state_r == DOD_ST_CONST) begin
      dec_op <= held_op_r;
      dec_undefined <= 1'b0;
    end else if (take_result) begin
      dec_op <= op_nxt;
      dec_undefined <= (op_nxt == DOD_OP_UNDEFINED);
    end
  end

  // constant of a long op; zero for one-word ops so stale data never leaks
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_const <= 16'h0000;
    end else if (word_valid && state_r == DOD_ST_CONST) begin
      dec_const <= word_in;
    end else if (take_result) begin
      dec_const <= 16'h0000;
    end
  end

  // address and immediate share the low byte; execute picks the meaning
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_addr_field <= 8'h00;
    end else if (take_result) begin
      dec_addr_field <= cur_low_byte;
    end
  end

  // immediate byte, also the repeat count
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_imm8 <= 8'h00;
    end else if (take_result) begin
      dec_imm8 <= cur_low_byte;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_shift <= 4'h0;
    end else if (take_result) begin
      // store forms carry three bits; every other form the low nibble
      if (cur_top_nib == DOD_N_STORE_ACC) begin
        dec_shift <= {1'b0, cur_shift3};
      end else begin
        dec_shift <= cur_low_nib;
      end
    end
  end

  // control bit, only for a set op on its own word
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_cbit <= DOD_CB_NONE;
    end else if (take_result) begin
      dec_cbit <= (op_nxt == DOD_OP_SET_CTRL && state_r == DOD_ST_FIRST) ? cbit_code
                                                                          : DOD_CB_NONE;
    end
  end

  // condition bits kept for execute; mask and value merged
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_cond_bits <= 8'h00;
    end else if (take_result) begin
      dec_cond_bits <= {cur_tp, cur_cond_mask | cur_low_nib, DOD_COND_PAD};
    end
  end

  // word count; a long form reports two though one result fires
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_words <= 2'h0;
    end else if (take_result) begin
      dec_words <= w_cnt;
    end
  end

  // cycle counts; only a return has differing taken and not-taken
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_cyc_taken <= 3'h0;
      dec_cyc_not <= 3'h0;
    end else if (take_result) begin
      dec_cyc_taken <= c_taken;
      dec_cyc_not <= c_not;
    end
  end
endmodule // dod_decoder
`default_nettype wire

// File: tb/dod_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module dod_fetch_model (
  input wire logic ref_clk,
  output var logic word_valid,
  output var logic [15:0] word_in
);
  // ----
  // fetch side
  // ----
  initial begin
    word_valid = 1'b0;
    word_in = 16'h0000;
  end
  // one word for one clock, changed off the sampling edge
  task automatic send(input logic [15:0] w);
    @(negedge ref_clk);
    word_valid = 1'b1;
    word_in = w;
  endtask
  // released bus flips so a stale word never looks valid
  task automatic idle();
    @(negedge ref_clk);
    word_valid = 1'b0;
    word_in = ~word_in;
  endtask
endmodule // dod_fetch_model
`default_nettype wire

// File: tb/dod_decoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dod_decoder_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic word_valid,
  input wire logic [15:0] word_in,
  input wire logic dec_valid,
  input wire dod_pkg::dod_op_t dec_op,
  input wire logic [15:0] dec_const,
  input wire dod_pkg::dod_cbit_t dec_cbit,
  input wire logic [1:0] dec_words,
  input wire logic [2:0] dec_cyc_taken,
  input wire logic [2:0] dec_cyc_not,
  input wire logic dec_undefined,
  input wire logic want_const
);
  import dod_pkg::*;
  // ----
  // decode checks
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // a fresh opcode, not a pending constant word
  logic op_in;
  assign op_in = word_valid && !want_const;
  a_pop_acc_decode: assert property (op_in && word_in == 16'hbe32 |=>
    dec_valid && dec_op == DOD_OP_POP_ACC && dec_words == 2'h1) else $error("pop decode");
  a_cond_ret_cycles: assert property (op_in && word_in[15:10] == 6'h3b |=>
    dec_op == DOD_OP_COND_RET && dec_cyc_taken == 3'h4 && dec_cyc_not == 3'h2)
    else $error("cond return cycles");
  a_store_high_sel: assert property (op_in && word_in[15:11] == 5'h13 |=>
    dec_op == DOD_OP_STORE_HIGH) else $error("store high select");
  a_carry_select: assert property (op_in && word_in == 16'hbe4f |=>
    dec_op == DOD_OP_SET_CTRL && dec_cbit == DOD_CB_CARRY) else $error("carry select");
  a_long_holds: assert property (op_in && word_in[15:8] == 8'hae |=>
    want_const && !dec_valid) else $error("long store not held");
  a_xor16_pending: assert property (op_in && word_in == 16'hbe83 |=>
    want_const) else $error("xor long not pending");
  a_const_wait: assert property (want_const && !word_valid |=>
    want_const && !dec_valid) else $error("constant wait dropped");
  a_const_taken: assert property (want_const && word_valid |=>
    dec_valid && !want_const && dec_words == 2'h2 && dec_const == $past(word_in))
    else $error("constant not taken");
  a_sub_product: assert property (op_in && word_in == 16'hbe05 |=>
    dec_op == DOD_OP_SUB_PRODUCT && dec_cyc_taken == 3'h1) else $error("product sub");
  a_undef_level: assert property (dec_valid |->
    dec_undefined == (dec_op == DOD_OP_UNDEFINED)) else $error("undefined flag");
  c_two_word: cover property (want_const ##1 dec_valid);
  c_undefined: cover property (dec_valid && dec_undefined);
  c_back_to_back: cover property (dec_valid ##1 dec_valid);
endmodule // dod_decoder_checker
bind dod_decoder dod_decoder_checker i_chk (.ref_clk(ref_clk), .nrst(nrst),
  .word_valid(word_valid), .word_in(word_in), .dec_valid(dec_valid), .dec_op(dec_op),
  .dec_const(dec_const), .dec_cbit(dec_cbit), .dec_words(dec_words),
  .dec_cyc_taken(dec_cyc_taken), .dec_cyc_not(dec_cyc_not),
  .dec_undefined(dec_undefined), .want_const(want_const));
`default_nettype wire

// File: tb/tb_dsp_opcode_decoder_tail.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_opcode_decoder_tail;
  import dod_pkg::*;
  logic ref_clk;
  logic nrst;
  logic word_valid;
  logic [15:0] word_in;
  logic dec_valid;
  dod_op_t dec_op;
  logic [7:0] dec_addr_field;
  logic [7:0] dec_imm8;
  logic [3:0] dec_shift;
  logic [15:0] dec_const;
  dod_cbit_t dec_cbit;
  logic [7:0] dec_cond_bits;
  logic [1:0] dec_words;
  logic [2:0] dec_cyc_taken;
  logic [2:0] dec_cyc_not;
  logic dec_undefined;
  logic want_const;
  int num_errors;
  int compares;
  dod_fetch_model i_fetch (.ref_clk(ref_clk), .word_valid(word_valid), .word_in(word_in));
  dod_decoder i_dut (.ref_clk(ref_clk), .nrst(nrst), .word_valid(word_valid),
    .word_in(word_in), .dec_valid(dec_valid), .dec_op(dec_op),
    .dec_addr_field(dec_addr_field), .dec_imm8(dec_imm8), .dec_shift(dec_shift),
    .dec_const(dec_const), .dec_cbit(dec_cbit), .dec_cond_bits(dec_cond_bits),
    .dec_words(dec_words), .dec_cyc_taken(dec_cyc_taken), .dec_cyc_not(dec_cyc_not),
    .dec_undefined(dec_undefined), .want_const(want_const));
  // 125 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ----
  // shared checks
  // ----
  task automatic results();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-word op; result is looked at in its single valid cycle
  task automatic op1(input logic [15:0] w, input dod_op_t op, input logic [2:0] ct,
                     input logic [2:0] cn);
    i_fetch.send(w);
    i_fetch.idle();
    chk(dec_valid, 1);
    chk(dec_op, op);
    chk(dec_undefined, op == DOD_OP_UNDEFINED);
    chk(dec_const, 0);
    if (op != DOD_OP_UNDEFINED) begin
      chk(dec_words, 1);
      chk(dec_cyc_taken, ct);
      chk(dec_cyc_not, cn);
    end
  endtask
  // two-word op with a gap while the constant is pending
  task automatic lw(input logic [15:0] w, input logic [15:0] c, input dod_op_t op);
    i_fetch.send(w);
    i_fetch.idle();
    chk(want_const, 1);
    chk(dec_valid, 0);
    i_fetch.idle();
    chk(want_const, 1);
    i_fetch.send(c);
    i_fetch.idle();
    chk(dec_valid, 1);
    chk(dec_op, op);
    chk(dec_const, c);
    chk(dec_words, 2);
    chk(dec_cyc_taken, 2);
    chk(dec_cyc_not, 2);
    chk(dec_undefined, 0);
    chk(want_const, 0);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_stack();
    op1(16'hbe32, DOD_OP_POP_ACC, 1, 1);
    op1(16'h8a55, DOD_OP_POP_MEM, 1, 1);
    chk(dec_addr_field, 8'h55);
    op1(16'h76a3, DOD_OP_PUSH_MEM, 1, 1);
    op1(16'hbe3c, DOD_OP_PUSH_ACC, 1, 1);
    // back to back, no idle between the words
    i_fetch.send(16'hbe32);
    i_fetch.send(16'hbe3c);
    chk(dec_op, DOD_OP_POP_ACC);
    i_fetch.idle();
    chk(dec_op, DOD_OP_PUSH_ACC);
    $display("test stack done");
  endtask
  task automatic t_ctrl();
    logic [3:0] nib [7] = '{4'hf, 4'h5, 4'h1, 4'h3, 4'hb, 4'hd, 4'h7};
    for (int i = 0; i < 7; i++) begin
      op1({12'hbe4, nib[i]}, DOD_OP_SET_CTRL, 1, 1);
      chk(dec_cbit, i + 1);
    end
    op1(16'hbe40, DOD_OP_UNDEFINED, 1, 1);
    op1(16'h5100, DOD_OP_UNDEFINED, 1, 1);
    $display("test control done");
  endtask
  task automatic t_misc();
    op1(16'hec37, DOD_OP_COND_RET, 4, 2);
    chk(dec_cond_bits, 8'h1c);
    op1(16'hed51, DOD_OP_COND_RET, 4, 2);
    chk(dec_cond_bits, 8'h54);
    op1(16'hbb7f, DOD_OP_REPEAT_IMM, 1, 1);
    chk(dec_imm8, 8'h7f);
    op1(16'h0b10, DOD_OP_REPEAT_MEM, 1, 1);
    op1(16'h9d21, DOD_OP_STORE_HIGH, 1, 1);
    chk(dec_shift, 4'h5);
    op1(16'h9321, DOD_OP_STORE_LOW, 1, 1);
    chk(dec_shift, 4'h3);
    op1(16'h7c80, DOD_OP_AUX_SUB_IMM, 1, 1);
    chk(dec_imm8, 8'h80);
    op1(16'h8e01, DOD_OP_STORE_STATUS_ZERO, 1, 1);
    op1(16'h8f02, DOD_OP_STORE_STATUS_ONE, 1, 1);
    $display("test misc done");
  endtask
  task automatic t_sub_no_sign_ext();
    op1(16'hbaff, DOD_OP_SUB_SHORT, 1, 1);
    chk(dec_imm8, 8'hff);
    op1(16'h6400, DOD_OP_SUB_BORROW, 1, 1);
    op1(16'h66c4, DOD_OP_SUB_NO_SEXT, 1, 1);
    op1(16'h6711, DOD_OP_SUB_BY_TEMP, 1, 1);
    op1(16'h6822, DOD_OP_ZERO_LD_RND, 1, 1);
    op1(16'h5333, DOD_OP_SQUARE_SUB, 1, 1);
    op1(16'hbe05, DOD_OP_SUB_PRODUCT, 1, 1);
    $display("test subtract done");
  endtask
  task automatic t_long();
    lw(16'hae12, 16'h1234, DOD_OP_STORE_LONG);
    chk(dec_addr_field, 8'h12);
    lw(16'hbfa3, 16'h8000, DOD_OP_SUB_LONG);
    chk(dec_shift, 4'h3);
    // constant that looks like an opcode is still data
    lw(16'hbe83, 16'hbe32, DOD_OP_XOR_LONG16);
    $display("test long done");
  endtask
  // reset while a constant is pending drops the pending state
  task automatic t_reset();
    i_fetch.send(16'hae40);
    i_fetch.idle();
    chk(want_const, 1);
    nrst = 1'b0;
    @(negedge ref_clk);
    chk(want_const, 0);
    chk(dec_valid, 0);
    nrst = 1'b1;
    op1(16'hbe32, DOD_OP_POP_ACC, 1, 1);
    $display("test reset done");
  endtask
  // main sequence
  initial begin
    num_errors = 0;
    compares = 0;
    nrst = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk(want_const, 0);
    nrst = 1'b1;
    t_stack();
    t_ctrl();
    t_misc();
    t_sub_no_sign_ext();
    t_long();
    t_reset();
    results();
  end
  // watchdog, well beyond the hundred or so cycles the tests need
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    $display("watchdog expired");
    results();
  end
endmodule // tb_dsp_opcode_decoder_tail
`default_nettype wire
